// ==== rtl/cdsp_pkg.sv ====
// Constants, field layouts and types of the current converter serial port.
// Assumes one 24-bit frame per load strobe: 8 address bits then 16 data bits.
package cdsp_pkg;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Address byte codes
  localparam logic [7:0] ADDR_NOP = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h01;
  localparam logic [7:0] ADDR_READ = 8'h02;
  localparam logic [7:0] ADDR_CTRL = 8'h55;

  // Readback selectors in the low data bits of a read frame
  localparam logic [1:0] RB_SEL_STATUS = 2'h0;
  localparam logic [1:0] RB_SEL_DATA = 2'h1;
  localparam logic [1:0] RB_SEL_CTRL = 2'h2;

  // ----------------------------------------------------------------------
  // Control and status fields
  // ----------------------------------------------------------------------
  localparam int CTRL_RANGE_LSB = 0;
  localparam int CTRL_DAISY_BIT = 3;
  localparam logic [1:0] RANGE_RESERVED = 2'h3;
  localparam int STAT_OPEN_BIT = 0;
  localparam int STAT_OT_BIT = 1;
  localparam int STAT_CLEAR_BIT = 2;

  typedef enum logic [1:0] {
    CDSP_RANGE_4_20 = 2'h0,
    CDSP_RANGE_0_20 = 2'h1,
    CDSP_RANGE_0_24 = 2'h2
  } cdsp_range_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cdsp_word_t;

  typedef struct packed {
    logic daisy;
    cdsp_range_t range;
  } cdsp_ctrl_t;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam cdsp_ctrl_t CTRL_RESET = '{daisy: 1'b0, range: CDSP_RANGE_4_20};
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] ZERO_CODE = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;

endpackage

// ==== rtl/cdsp_sync.sv ====
// Two flip-flop synchroniser for one level signal.
// Assumes the input is a level that stays put for at least two clock edges.
`timescale 1ns/1ps
module cdsp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock, enable, reset
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic i_resetn,
  // Level in and out
  input wire logic i_async,
  output logic o_sync
);

  logic stage1;
  logic next_stage1;
  logic next_sync;

  // First stage feeds only the second one
  always_comb begin
    next_stage1 = i_ce ? i_async : stage1;
    next_sync = i_ce ? stage1 : o_sync;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      stage1 <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      stage1 <= next_stage1;
      o_sync <= next_sync;
    end
  end

endmodule

// ==== rtl/cdsp_top.sv ====
// Serial port, load logic and digital pins of a current-output converter.
// Assumes a host that frames 24 bits on its own serial clock, then raises
// the load strobe while the serial clock is idle.
`timescale 1ns/1ps
// Behaviour
// - Shift serial input into shift register on each serial clock rise, up to 30 MHz.
// - Load strobe rise copies the 16 data bits into the data register, or the daisy and range bits into the control register.
// - Loading the data register also updates the output current code.
// - Readback or daisy-chain output bits change on serial clock falls.
// - Clear input forces the output code to zero scale of the range.
// - Fault flag pulls low on open loop or overtemperature.
// - Fault pin is open drain: pulls low or releases the line.
// - With daisy-chain mode off, readback output releases after the next load strobe rise that is not another read request.
// - Output range, one of three, comes from the control register.
module cdsp_top
  import cdsp_pkg::*;
(
  // Clock, enable, reset
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic i_resetn,
  // Serial link
  input wire logic i_sclk,
  input wire logic i_serial_in,
  input wire logic i_latch,
  output logic o_serial_out,
  output logic o_serial_out_en_n,
  // Analog side
  input wire logic i_clear,
  input wire logic i_open_loop,
  input wire logic i_overtemp,
  output logic [DATA_W-1:0] o_dac_code,
  output cdsp_range_t o_range,
  output logic o_zero_scale,
  // Fault pin
  output logic o_fault_out,
  output logic o_fault_en_n
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic latch_s;
  logic clear_s;
  logic open_s;
  logic ot_s;
  logic link_rst_n;

  cdsp_sync #(.RST_VAL(1'b0)) u_sync_latch (
    .i_clk(i_clk), .i_ce(i_ce), .i_resetn(i_resetn), .i_async(i_latch), .o_sync(latch_s)
  );
  cdsp_sync #(.RST_VAL(1'b0)) u_sync_clear (
    .i_clk(i_clk), .i_ce(i_ce), .i_resetn(i_resetn), .i_async(i_clear), .o_sync(clear_s)
  );
  cdsp_sync #(.RST_VAL(1'b0)) u_sync_open (
    .i_clk(i_clk), .i_ce(i_ce), .i_resetn(i_resetn), .i_async(i_open_loop),
    .o_sync(open_s)
  );
  cdsp_sync #(.RST_VAL(1'b0)) u_sync_ot (
    .i_clk(i_clk), .i_ce(i_ce), .i_resetn(i_resetn), .i_async(i_overtemp), .o_sync(ot_s)
  );
  // Reset carried into the serial clock domain; needs link edges to act
  cdsp_sync #(.RST_VAL(1'b0)) u_sync_link_rst (
    .i_clk(i_sclk), .i_ce(1'b1), .i_resetn(1'b1), .i_async(i_resetn), .o_sync(link_rst_n)
  );

  // ----------------------------------------------------------------------
  // Link domain: shift register and serial output
  // ----------------------------------------------------------------------
  logic [WORD_W-1:0] shift;
  logic [WORD_W-1:0] next_shift;
  logic rb_ack;
  logic next_rb_ack;
  logic next_serial_out;
  logic rb_pending;
  logic rb_tog;
  logic [WORD_W-1:0] rb_word;

  // A pending readback preloads the word on the first rise of the frame.
  // Toggle and word are set while the link clock is idle, so they are
  // settled long before that rise; top word bit is lost to the preload.
  always_comb begin
    rb_pending = (rb_tog != rb_ack);
    if (rb_pending) begin
      next_shift = {rb_word[WORD_W-2:0], i_serial_in};
    end else begin
      next_shift = {shift[WORD_W-2:0], i_serial_in};
    end
    next_rb_ack = rb_tog;
    next_serial_out = shift[WORD_W-1];
  end

  always_ff @(posedge i_sclk) begin
    if (!link_rst_n) begin
      shift <= WORD_RESET;
      rb_ack <= 1'b0;
    end else begin
      shift <= next_shift;
      rb_ack <= next_rb_ack;
    end
  end

  // Output bit moves on falling edges, half a period ahead of host sampling
  always_ff @(negedge i_sclk) begin
    if (!link_rst_n) begin
      o_serial_out <= 1'b0;
    end else begin
      o_serial_out <= next_serial_out;
    end
  end

  // ----------------------------------------------------------------------
  // Main domain: load decode and registers
  // ----------------------------------------------------------------------
  cdsp_word_t word;
  logic latch_d;
  logic latch_rise;
  logic [DATA_W-1:0] data_reg;
  cdsp_ctrl_t ctrl;
  logic rb_active;
  logic [DATA_W-1:0] next_data;
  cdsp_ctrl_t next_ctrl;
  logic next_rb_active;
  logic next_rb_tog;
  logic [WORD_W-1:0] next_rb_word;
  logic [DATA_W-1:0] rb_value;
  logic [DATA_W-1:0] status_word;

  // Shift register is quiet while the strobe is high, so reading it here
  // on the synchronised rise is safe as long as the host waits
  assign word = cdsp_word_t'(shift);
  assign latch_rise = latch_s & ~latch_d;

  // Status image for readback
  always_comb begin
    status_word = ZERO_CODE;
    status_word[STAT_OPEN_BIT] = open_s;
    status_word[STAT_OT_BIT] = ot_s;
    status_word[STAT_CLEAR_BIT] = clear_s;
    unique case (word.data[1:0])
      RB_SEL_DATA: rb_value = data_reg;
      RB_SEL_CTRL: begin
        rb_value = ZERO_CODE;
        rb_value[CTRL_DAISY_BIT] = ctrl.daisy;
        rb_value[CTRL_RANGE_LSB +: 2] = ctrl.range;
      end
      default: rb_value = status_word;
    endcase
  end

  // Only a strobe rise may alter the registers
  always_comb begin
    next_data = data_reg;
    next_ctrl = ctrl;
    next_rb_active = rb_active;
    next_rb_tog = rb_tog;
    next_rb_word = rb_word;
    if (latch_rise) begin
      next_rb_active = 1'b0;
      unique case (word.addr)
        ADDR_DATA: next_data = word.data;
        ADDR_CTRL: begin
          next_ctrl.daisy = word.data[CTRL_DAISY_BIT];
          // Reserved range code keeps the old range
          if (word.data[CTRL_RANGE_LSB +: 2] != RANGE_RESERVED) begin
            next_ctrl.range = cdsp_range_t'(word.data[CTRL_RANGE_LSB +: 2]);
          end
        end
        ADDR_READ: begin
          next_rb_active = 1'b1;
          next_rb_tog = ~rb_tog;
          next_rb_word = {ADDR_READ, rb_value};
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      latch_d <= 1'b0;
      data_reg <= DATA_RESET;
      ctrl <= CTRL_RESET;
      rb_active <= 1'b0;
      rb_tog <= 1'b0;
      rb_word <= WORD_RESET;
    end else if (i_ce) begin
      latch_d <= latch_s;
      data_reg <= next_data;
      ctrl <= next_ctrl;
      rb_active <= next_rb_active;
      rb_tog <= next_rb_tog;
      rb_word <= next_rb_word;
    end
  end

  // ----------------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] next_dac_code;
  cdsp_range_t next_range;
  logic next_zero_scale;
  logic next_fault_en_n;
  logic next_so_en_n;

  // Clear wins over the loaded code; code zero is the low end of any range
  always_comb begin
    next_dac_code = clear_s ? ZERO_CODE : data_reg;
    next_zero_scale = clear_s;
    next_range = ctrl.range;
    next_fault_en_n = ~(open_s | ot_s);
    next_so_en_n = ~(ctrl.daisy | rb_active);
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_dac_code <= ZERO_CODE;
      o_range <= CTRL_RESET.range;
      o_zero_scale <= 1'b0;
      o_fault_out <= 1'b0;
      o_fault_en_n <= 1'b1;
      o_serial_out_en_n <= 1'b1;
    end else if (i_ce) begin
      o_dac_code <= next_dac_code;
      o_range <= next_range;
      o_zero_scale <= next_zero_scale;
      o_fault_out <= 1'b0;
      o_fault_en_n <= next_fault_en_n;
      o_serial_out_en_n <= next_so_en_n;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_data_load;
    latch_rise && i_ce && (word.addr == ADDR_DATA);
  endsequence

  sequence s_quiet_clear;
    !clear_s && i_ce;
  endsequence

  chk_shift_in: assert property (
    @(posedge i_sclk) disable iff (!link_rst_n)
    !rb_pending |=> (shift == {$past(shift[WORD_W-2:0]), $past(i_serial_in)}))
    else $error("shift register did not take the serial bit");

  chk_out_fall: assert property (
    @(negedge i_sclk) disable iff (!link_rst_n)
    link_rst_n |=> (o_serial_out == $past(shift[WORD_W-1])))
    else $error("serial output did not follow on the falling edge");

  chk_data_load: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_data_load |=> (data_reg == $past(word.data)))
    else $error("data register missed the strobe load");

  chk_out_update: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_data_load ##1 s_quiet_clear |=> (o_dac_code == $past(word.data, 2)))
    else $error("output code not updated after data load");

  chk_zero_scale: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (clear_s && i_ce) |=> (o_zero_scale && (o_dac_code == ZERO_CODE)))
    else $error("clear did not force zero scale");

  chk_fault_pull: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce |=> (o_fault_en_n == !($past(open_s) || $past(ot_s))))
    else $error("fault pin drive does not match fault state");

  chk_fault_level: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !o_fault_en_n |-> (o_fault_out == 1'b0))
    else $error("fault pin driven to a high level");

  chk_so_release: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (latch_rise && i_ce && (word.addr != ADDR_READ) && (word.addr != ADDR_CTRL)
      && !ctrl.daisy) ##1 i_ce |=> o_serial_out_en_n)
    else $error("serial output not released after strobe");

  chk_rb_drive: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (latch_rise && i_ce && (word.addr == ADDR_READ)) ##1 i_ce |=> !o_serial_out_en_n)
    else $error("serial output not driven after read request");

  chk_range_sel: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (latch_rise && i_ce && (word.addr == ADDR_CTRL)
      && (word.data[CTRL_RANGE_LSB +: 2] != RANGE_RESERVED)) ##1 i_ce
      |=> (o_range == $past(word.data[CTRL_RANGE_LSB +: 2], 2)))
    else $error("range not taken from control write");

  chk_no_load: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !latch_rise |=> ($stable(data_reg) && $stable(ctrl)))
    else $error("register changed without a strobe rise");

endmodule

// ==== dv/cdsp_host_model.sv ====
// Host serial master model: frames 24-bit words and pulses the load strobe.
// Assumes the bench calls one task at a time; the serial clock is idle low.
`timescale 1ns/1ps
module cdsp_host_model (
  // Serial link towards the device
  output logic o_sclk,
  output logic o_serial_in,
  output logic o_latch,
  // Readback line from the device
  input wire logic i_serial_out,
  input wire logic i_serial_out_en_n
);
  // Idle levels at time zero
  initial begin
    o_sclk = 1'b0;
    o_serial_in = 1'b0;
    o_latch = 1'b0;
  end

  // Bare clock pulses, used during reset and after its release to carry it into and out of the link domain
  task automatic pulses(input int n);
    repeat (n) begin
      #24 o_sclk = 1'b1;
      #24 o_sclk = 1'b0;
    end
  endtask

  // One frame MSB first; records the line level seen at every rise
  task automatic frame(input logic [23:0] w, output logic [23:0] got);
    for (int i = 23; i >= 0; i--) begin
      o_serial_in = w[i]; // Settled a half period before the rise
      #24 o_sclk = 1'b1;
      got[i] = i_serial_out_en_n ? 1'bx : i_serial_out; // Released line has no level
      #24 o_sclk = 1'b0;
    end
    o_serial_in = ~w[0]; // Stale bit not left on the line
  endtask

  // Strobe with the clock idle; long hold after a control write
  task automatic strobe(input int hold_ns);
    #250 o_latch = 1'b1;
    #(hold_ns) o_latch = 1'b0;
    #100;
  endtask
endmodule

// ==== dv/cdsp_top_tb.sv ====
// Self-checking bench for the converter serial port and digital pins.
// Assumes the host model drives the link; outputs checked against notes.
`timescale 1ns/1ps
module cdsp_top_tb
  import cdsp_pkg::*;
;
  localparam logic [7:0] ADDR_SPARE = 8'h7e;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_ce = 1'b1;
  logic i_clear = 1'b0;
  logic i_open_loop = 1'b0;
  logic i_overtemp = 1'b0;
  logic sclk, serial_in, latch, serial_out, sdo_en_n, fault_out, fault_en_n, zs;
  logic [DATA_W-1:0] code, cur_code;
  cdsp_range_t rng;
  logic [1:0] cur_rng;
  logic daisy, rb_on;
  logic [20:0] exp_q[$];
  logic [20:0] note_v;
  logic [23:0] got;
  int mismatches = 0;
  int checks_done = 0;
  event chk_ev;

  // Main clock, 25 ns period
  always #12.5 i_clk = ~i_clk;

  // ----------------------------------------------------------------------
  // Device and host
  // ----------------------------------------------------------------------
  cdsp_top u_cdsp_top (.i_clk(i_clk), .i_ce(i_ce), .i_resetn(i_resetn), .i_sclk(sclk),
    .i_serial_in(serial_in), .i_latch(latch), .o_serial_out(serial_out), .o_serial_out_en_n(sdo_en_n),
    .i_clear(i_clear), .i_open_loop(i_open_loop), .i_overtemp(i_overtemp),
    .o_dac_code(code), .o_range(rng), .o_zero_scale(zs), .o_fault_out(fault_out),
    .o_fault_en_n(fault_en_n));
  cdsp_host_model u_cdsp_host_model (.o_sclk(sclk), .o_serial_in(serial_in), .o_latch(latch),
    .i_serial_out(serial_out), .i_serial_out_en_n(sdo_en_n));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] expv);
    checks_done++;
    if (seen !== expv) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, expv, seen);
    end
  endtask

  task automatic complete_run();
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Note the expected outputs, then let the slowest path settle
  task automatic note();
    exp_q.push_back({i_clear ? ZERO_CODE : cur_code, cur_rng, i_clear,
      ~(i_open_loop | i_overtemp), ~(daisy | rb_on)});
    repeat (10) @(posedge i_clk);
    // Off the edge, so the monitor sees settled register outputs
    #2 ->chk_ev;
  endtask

  // Whole write: frame, strobe, bench-side register model, note
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_cdsp_host_model.frame({a, d}, got);
    u_cdsp_host_model.strobe(a == ADDR_CTRL ? 5200 : 300);
    if (a == ADDR_DATA) cur_code = d;
    if (a == ADDR_CTRL && d[1:0] != RANGE_RESERVED) cur_rng = d[1:0];
    if (a == ADDR_CTRL) daisy = d[CTRL_DAISY_BIT];
    rb_on = (a == ADDR_READ);
    note();
  endtask

  // Read request, then a no-op frame that carries the answer out
  task automatic rd(input logic [1:0] sel, input logic [15:0] expv);
    wr(ADDR_READ, {14'h0, sel});
    wr(ADDR_NOP, 16'h0000);
    check("readback", {8'h0, got[15:0]}, {8'h0, expv});
  endtask

  // Monitor: oldest note against the settled outputs
  always @(chk_ev) begin
    note_v = exp_q.pop_front();
    check("outputs", {3'h0, code, rng, zs, fault_en_n, sdo_en_n},
      {3'h0, note_v});
    check("fault_out", {23'h0, fault_out}, 24'h0);
  end

  // Watchdog: the run needs well under 200 us
  initial begin
    #500000;
    mismatches++;
    complete_run();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(3));
    cur_code = DATA_RESET;
    cur_rng = CDSP_RANGE_4_20;
    daisy = 1'b0;
    rb_on = 1'b0;
    // Reset longer than 4 cycles: the link side needs 3 rises too
    #2 u_cdsp_host_model.pulses(4);
    @(posedge i_clk);
    #2 i_resetn = 1'b1;
    u_cdsp_host_model.pulses(3);
    note();
    for (int i = 0; i < 3; i++) wr(ADDR_DATA, 16'($urandom()));
    for (int r = 3; r >= 0; r--) wr(ADDR_CTRL, 16'(r)); // Reserved code first
    u_cdsp_host_model.frame({ADDR_DATA, 16'hbeef}, got); // No strobe
    note();
    // Enable low: the strobe is never seen, so nothing loads
    @(posedge i_clk);
    #2 i_ce = 1'b0;
    u_cdsp_host_model.frame({ADDR_DATA, 16'h0f0f}, got);
    u_cdsp_host_model.strobe(300);
    note();
    @(posedge i_clk);
    #2 i_ce = 1'b1;
    note();
    wr(ADDR_SPARE, 16'h5a5a); // Unmapped address changes nothing
    rd(RB_SEL_DATA, cur_code);
    rd(RB_SEL_CTRL, {12'h0, daisy, 1'b0, cur_rng});
    // Each fault and clear alone, read back through status
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clk);
      #2 {i_clear, i_overtemp, i_open_loop} = 3'(1 << k);
      note();
      rd(RB_SEL_STATUS, 16'(1 << k));
    end
    wr(ADDR_DATA, 16'hc3a5); // Loaded under clear, output held at zero
    @(posedge i_clk);
    #2 i_clear = 1'b0;
    note();
    // Chain mode: the next frame shifts out the previous word
    wr(ADDR_CTRL, 16'h0008 | 16'(cur_rng));
    wr(ADDR_NOP, 16'h9c35);
    u_cdsp_host_model.frame(24'h00a50f, got);
    check("chain", got, {ADDR_NOP, 16'h9c35});
    wr(ADDR_CTRL, 16'(cur_rng));
    // Let the monitor finish its last compare before the verdict
    @(posedge i_clk);
    complete_run();
  end
endmodule
